// >>> rtl/afr_defines.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  alert filter, conversion rate and identification register bank.
  Assumes inclusion by bare name from the design module.
*/
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH

// Pointer addresses
`define AFR_PTR_RATE_RD      8'h04
`define AFR_PTR_RATE_WR      8'h0A
`define AFR_PTR_HYST         8'h21
`define AFR_PTR_CONSEC       8'h22
`define AFR_PTR_MAKER_ID     8'hFE
`define AFR_PTR_PART_ID      8'hFF

// Reset values
`define AFR_RATE_RESET       4'h8
`define AFR_HYST_RESET       8'h0A
`define AFR_CONSEC_RESET     8'h81

// Consecutive alert register fields
`define AFR_CONSEC_TO_BIT    7
`define AFR_CONSEC_CNT_HI    3
`define AFR_CONSEC_CNT_LO    1

// Fastest rate code (4 per second) and clock rate
`define AFR_RATE_MAX_CODE    4'h6
`define AFR_CLK_HZ           50000000

// Conversion timing: slowest period in seconds, conversion length in cycles
`define AFR_SLOW_SECONDS     16
`define AFR_CONV_CYCLES      1000

`endif

// >>> rtl/afr_pkg.sv
/*
  Types shared by the alert filter register bank.
  Assumes afr_defines.svh is on the include path.
*/
package afr_pkg;

  // One host register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } afr_req_t;

  // One completed measurement from the converter, per channel
  typedef struct packed {
    logic [1:0] valid;
    logic [1:0] out_of_limit;
  } afr_meas_t;

endpackage

// >>> rtl/afr_regs.sv
/*
  Conversion rate, identification, consecutive alert filter and thermal
  hysteresis registers, plus the conversion pacing and alert filter logic.
  Assumes a bus engine that presents one-cycle read or write strobes with a
  pointer, and a converter that reports per-channel results as strobes.
*/
`timescale 1ns/1ps
`include "afr_defines.svh"

module afr_regs
  import afr_pkg::*;
#(
  parameter logic [7:0] MAKER_ID       = 8'hA5, // Arbitrary value
  parameter logic [7:0] PART_ID        = 8'h3C, // Arbitrary value
  parameter int         SLOW_PERIOD    = `AFR_SLOW_SECONDS * `AFR_CLK_HZ, // Period at code 0
  parameter int         CONV_CYCLES    = `AFR_CONV_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register access from the bus engine
  input  wire afr_req_t   req,
  output logic [7:0]      rdata_q,
  output logic            rvalid_q,
  // Converter pacing and results, alert mode and alert clear
  output logic            conv_start_q,
  input  wire afr_meas_t  meas,
  input  wire logic       alert_mode,
  input  wire logic       alert_clear,
  // Values to comparators and timeout logic, and the alert output
  output logic [7:0]      hysteresis_value_field_q,
  output logic            bus_timeout_enable_q,
  output logic            alert_or_second_thermal_output_n_q
);

  typedef enum {AFR_IDLE, AFR_CONVERT} afr_state_t;

  // Reset image of the consecutive alert register, for its stored fields
  localparam logic [7:0] CONSEC_RST = `AFR_CONSEC_RESET;

  logic [3:0]  rate_select_q;
  logic [2:0]  consec_count_q;
  logic [1:0]  hit_cnt_q [2];
  logic [31:0] timer_q;
  afr_state_t  state_q;

  // Count code to required number minus one
  function automatic logic [1:0] afr_need(input logic [2:0] code);
    case (code)
      3'b001:  afr_need = 2'd1;
      3'b011:  afr_need = 2'd2;
      3'b111:  afr_need = 2'd3;
      default: afr_need = 2'd0;
    endcase
  endfunction

  // Idle cycles for a rate code: period halves per step, clamped at 4/s
  function automatic logic [31:0] afr_idle(input logic [3:0] code);
    logic [3:0]  c;
    logic [31:0] per;
    c   = (code > `AFR_RATE_MAX_CODE) ? `AFR_RATE_MAX_CODE : code;
    per = 32'(SLOW_PERIOD) >> c;
    afr_idle = (per > 32'(CONV_CYCLES)) ? per - 32'(CONV_CYCLES) : 32'd1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_select_q            <= `AFR_RATE_RESET;
      hysteresis_value_field_q <= `AFR_HYST_RESET;
      bus_timeout_enable_q     <= CONSEC_RST[`AFR_CONSEC_TO_BIT];
      consec_count_q           <= CONSEC_RST[`AFR_CONSEC_CNT_HI:`AFR_CONSEC_CNT_LO];
    end else if (req.wr) begin
      if (req.ptr == `AFR_PTR_RATE_WR) begin
        rate_select_q <= req.wdata[3:0];
      end else if (req.ptr == `AFR_PTR_HYST) begin
        // Comparators outside subtract this from every high limit
        hysteresis_value_field_q <= req.wdata;
      end else if (req.ptr == `AFR_PTR_CONSEC) begin
        bus_timeout_enable_q <= req.wdata[`AFR_CONSEC_TO_BIT];
        consec_count_q <= req.wdata[`AFR_CONSEC_CNT_HI:`AFR_CONSEC_CNT_LO];
      end
      // Identification pointers accept writes but store nothing
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        if (req.ptr == `AFR_PTR_RATE_RD) begin
          rdata_q <= {4'h0, rate_select_q};
        end else if (req.ptr == `AFR_PTR_HYST) begin
          rdata_q <= hysteresis_value_field_q;
        end else if (req.ptr == `AFR_PTR_CONSEC) begin
          rdata_q <= {bus_timeout_enable_q, 3'h0, consec_count_q, 1'b1};
        end else if (req.ptr == `AFR_PTR_MAKER_ID) begin
          rdata_q <= MAKER_ID;
        end else if (req.ptr == `AFR_PTR_PART_ID) begin
          rdata_q <= PART_ID;
        end else begin
          rdata_q <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion pacing: fixed conversion time, rate sets idle gap
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q      <= AFR_IDLE;
      timer_q      <= 32'd1;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        AFR_IDLE: begin
          if (timer_q <= 32'd1) begin
            state_q      <= AFR_CONVERT;
            conv_start_q <= 1'b1;
            timer_q      <= 32'(CONV_CYCLES);
          end else begin
            timer_q <= timer_q - 32'd1;
          end
        end
        AFR_CONVERT: begin
          if (timer_q <= 32'd1) begin
            state_q <= AFR_IDLE;
            timer_q <= afr_idle(rate_select_q);
          end else begin
            timer_q <= timer_q - 32'd1;
          end
        end
        default: state_q <= AFR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel consecutive counters; status flags bypass this path
  always_ff @(posedge clk) begin
    if (reset) begin
      hit_cnt_q[0] <= 2'd0;
      hit_cnt_q[1] <= 2'd0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (meas.valid[ch]) begin
          if (!meas.out_of_limit[ch]) begin
            hit_cnt_q[ch] <= 2'd0;
          end else if (hit_cnt_q[ch] != 2'd3) begin
            hit_cnt_q[ch] <= hit_cnt_q[ch] + 2'd1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alert output, active low, held until cleared; set beats clear
  logic trip;
  always_comb begin
    trip = 1'b0;
    for (int ch = 0; ch < 2; ch++) begin
      if (meas.valid[ch] && meas.out_of_limit[ch]
          && hit_cnt_q[ch] >= afr_need(consec_count_q)) begin
        trip = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alert_or_second_thermal_output_n_q <= 1'b1;
    end else if (alert_mode && trip) begin
      alert_or_second_thermal_output_n_q <= 1'b0;
    end else if (alert_clear) begin
      alert_or_second_thermal_output_n_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_id_read_fixed: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.ptr == `AFR_PTR_PART_ID |=> rvalid_q && rdata_q == PART_ID)
    else $error("part code read wrong");
  chk_maker_read: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.ptr == `AFR_PTR_MAKER_ID |=> rdata_q == MAKER_ID)
    else $error("maker code read wrong");
  chk_consec_fixed_bits: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.ptr == `AFR_PTR_CONSEC |=> rdata_q[6:4] == 3'h0 && rdata_q[0])
    else $error("fixed bits of consecutive register wrong");
  chk_rate_upper_zero: assert property (@(posedge clk) disable iff (reset)
    req.rd && req.ptr == `AFR_PTR_RATE_RD |=> rdata_q[7:4] == 4'h0)
    else $error("rate upper bits not zero");
  chk_hyst_write: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.ptr == `AFR_PTR_HYST |=> hysteresis_value_field_q == $past(req.wdata))
    else $error("hysteresis write lost");
  chk_timeout_bit: assert property (@(posedge clk) disable iff (reset)
    req.wr && req.ptr == `AFR_PTR_CONSEC |=> bus_timeout_enable_q == $past(req.wdata[7]))
    else $error("timeout enable not updated");
  chk_in_limit_clears: assert property (@(posedge clk) disable iff (reset)
    meas.valid[0] && !meas.out_of_limit[0] |=> hit_cnt_q[0] == 2'd0)
    else $error("counter not cleared");
  chk_alert_needs_count: assert property (@(posedge clk) disable iff (reset)
    $fell(alert_or_second_thermal_output_n_q) |-> $past(trip && alert_mode))
    else $error("alert without enough consecutive hits");
  chk_conv_fixed_len: assert property (@(posedge clk) disable iff (reset)
    conv_start_q |-> state_q == AFR_CONVERT && timer_q == 32'(CONV_CYCLES))
    else $error("conversion length not fixed");
  chk_alert_holds_low: assert property (@(posedge clk) disable iff (reset)
    !alert_or_second_thermal_output_n_q && !alert_clear
    |=> !alert_or_second_thermal_output_n_q)
    else $error("alert released without clear");

endmodule

// >>> testbench/afr_host_model.sv
/*
  Host model that issues single-byte register reads and writes.
  Assumes the bank takes a strobe on the rising edge and needs no wait.
*/
`timescale 1ns/1ps

module afr_host_model
  import afr_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Request to the register bank
  output afr_req_t  req
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus until the first access
  initial begin
    req = '0;
  end

  // One-cycle strobe set and released at falling edges, never on the sampling edge
  task automatic access(input logic w, input logic [7:0] p, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: w, rd: !w, ptr: p, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask
endmodule

// >>> testbench/test_alert_filter_rate_id_regs.sv
/*
  Self-checking bench for the alert filter, rate and identification registers.
  Assumes the host model drives the bus; reads are checked through a queue.
*/
`timescale 1ns/1ps

module test_alert_filter_rate_id_regs
  import afr_pkg::*;
();
  logic clk = 1'b0;
  logic reset = 1'b1;
  afr_req_t req;
  logic [7:0] rdata_q, hyst;
  logic rvalid_q, conv_start_q, alert_mode = 1'b1, alert_clear = 1'b0, bus_timeout_enable, alert_n;
  afr_meas_t meas = '0;
  logic [7:0] exp_q[$];
  logic [2:0] codes[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [3:0] rates[4];
  logic [7:0] h;
  int err_count = 0;
  int checked = 0;
  localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3C; // Arbitrary value

  always #10 clk = ~clk;

  afr_host_model host (.clk(clk), .req(req));

  afr_regs #(.MAKER_ID(MAKER), .PART_ID(PART), .SLOW_PERIOD(640), .CONV_CYCLES(4)) uut (
    .clk(clk), .reset(reset), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .conv_start_q(conv_start_q), .meas(meas), .alert_mode(alert_mode),
    .alert_clear(alert_clear), .hysteresis_value_field_q(hyst),
    .bus_timeout_enable_q(bus_timeout_enable), .alert_or_second_thermal_output_n_q(alert_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.access(1'b1, p, d);
  endtask

  // Note the expected byte, then issue the read
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, p, 8'h00);
  endtask

  // One result on channel ch, then time for the filter to settle
  task automatic feed(input logic ch, input logic ool);
    @(negedge clk);
    meas <= '{valid: ch ? 2'b10 : 2'b01, out_of_limit: {ch & ool, !ch & ool}};
    @(negedge clk);
    meas <= '0;
    repeat (2) @(negedge clk);
  endtask

  // One-cycle alert clear, then one cycle to settle
  task automatic clear_alert();
    @(negedge clk);
    alert_clear <= 1'b1;
    @(negedge clk);
    alert_clear <= 1'b0;
    @(negedge clk);
  endtask

  // Cycles between two conversion starts, skipping the one in progress
  task automatic period(input int exp);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (conv_start_q !== 1'b1 && n < 2000);
    end
    chk(16'(n), 16'(exp));
  endtask

  // Monitor: every read answer retires the oldest note
  always @(negedge clk) begin
    if (!reset && rvalid_q === 1'b1) begin
      if (exp_q.size() == 0) chk(rdata_q, 16'hFFFF);
      else chk(rdata_q, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  initial begin
    void'($urandom(32'h183C));
    repeat (5) @(negedge clk);
    reset <= 1'b0;
    chk(bus_timeout_enable, 1'b1);
    chk(hyst, 8'h0A);
    rd(8'h04, 8'h08);
    rd(8'h21, 8'h0A);
    rd(8'h22, 8'h81);
    rd(8'hFE, MAKER);
    rd(8'hFF, PART);
    // Writes to read-only places leave them untouched
    wr(8'h04, 8'($urandom));
    wr(8'hFE, 8'($urandom));
    wr(8'hFF, 8'($urandom));
    rd(8'h04, 8'h08);
    rd(8'hFE, MAKER);
    rd(8'hFF, PART);
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h8F);
    chk(bus_timeout_enable, 1'b1);
    wr(8'h22, 8'h00);
    rd(8'h22, 8'h01);
    chk(bus_timeout_enable, 1'b0);
    h = 8'($urandom);
    wr(8'h21, h);
    rd(8'h21, h);
    chk(hyst, h);
    // Reset in mid-run brings the registers back to their defaults
    @(negedge clk);
    reset <= 1'b1;
    repeat (2) @(negedge clk);
    reset <= 1'b0;
    chk(bus_timeout_enable, 1'b1);
    chk(hyst, 8'h0A);
    rd(8'h22, 8'h81);
    rd(8'h04, 8'h08);
    // Each code on one channel: a miss, N-1 hits, a miss, N-1 hits and a miss on
    // the other channel stay quiet; the Nth hit trips and holds until cleared
    foreach (codes[i]) begin
      wr(8'h22, {4'h8, codes[i], 1'b0});
      rd(8'h22, {4'h8, codes[i], 1'b1});
      feed(i[0], 1'b0);
      repeat (i) feed(i[0], 1'b1);
      feed(i[0], 1'b0);
      repeat (i) feed(i[0], 1'b1);
      feed(!i[0], 1'b0);
      chk(alert_n, 1'b1);
      feed(i[0], 1'b1);
      chk(alert_n, 1'b0);
      repeat (3) @(negedge clk);
      chk(alert_n, 1'b0);
      clear_alert();
      chk(alert_n, 1'b1);
    end
    // A trip and a clear in the same cycle: the trip wins
    @(negedge clk);
    meas <= '{valid: 2'b10, out_of_limit: 2'b10};
    alert_clear <= 1'b1;
    @(negedge clk);
    meas <= '0;
    alert_clear <= 1'b0;
    @(negedge clk);
    chk(alert_n, 1'b0);
    clear_alert();
    alert_mode <= 1'b0;
    wr(8'h22, 8'h80);
    feed(1'b0, 1'b1);
    chk(alert_n, 1'b1);
    // Conversion pacing per rate code; codes above 6 run at the fastest rate
    rates = '{4'h6, 4'h3, 4'($urandom_range(6)), 4'h9};
    foreach (rates[i]) begin
      wr(8'h0A, {4'h0, rates[i]});
      rd(8'h04, {4'h0, rates[i]});
      period(640 >> ((rates[i] > 4'h6) ? 4'h6 : rates[i]));
    end
    repeat (3) @(negedge clk);
    chk(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule
